// ### acr_top.v
// acr_top: register bank and sample routing of the six-channel modulator
// assumes a plain register port, frames of six 24-bit samples plus bass
// Operation
// - select bit puts downmix left on channel 1
// - select bit puts downmix right on channel 2
// - select bit puts left-right average on channel 5
// - two-bit code picks channel 6 source
// - five enables gate inputs into the downmix
// - unused downmix bits never affect routing
// - am enable, sequence and intermediate frequency fields
// - format bit picks bcd or binary frequency
// - bcd thousands bit twelve, hundreds eleven-eight
// - bcd tens and units digits, zero default
// - binary frequency eleven bits, zero default
// - six nibbles map channels to pins
// - channel codes are zero based
// - any channel to any pin, repeats allowed
`default_nettype none
`include "acr_defs.vh"

module acr_top (
	input wire sys_clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	output reg reg_rvalid,
	input wire in_valid,
	output wire in_ready,
	input wire [`ACR_CH_W-1:0] in_mux_data,
	input wire [`ACR_SW-1:0] in_bass_data,
	output reg out_valid,
	input wire out_ready,
	output reg [`ACR_CH_W-1:0] out_pin_data,
	output reg am_enable,
	output reg [1:0] am_sequence,
	output reg am_if_low,
	output reg am_freq_binary,
	output reg [10:0] am_freq_khz,
	output reg am_freq_valid
);
	// programmed copies, written by software
	reg [31:0] dm_r; // downmix route select
	reg [31:0] am_r; // am avoidance control
	reg [31:0] outpin_r; // output pin route
	// active copies, loaded only between frames
	reg [31:0] act_dm_r; // routing in use
	reg [31:0] act_out_r; // pin mapping in use

	// fifo side
	wire fifo_valid; // a frame waits
	wire fifo_ready; // routing stage takes it
	wire [`ACR_FRAME_W-1:0] fifo_data; // oldest frame
	wire [`ACR_FIFO_AW:0] fifo_level; // frames held
	wire take; // frame routed this cycle

	// routing intermediates
	reg [`ACR_SW-1:0] in_s [0:`ACR_NCH-1]; // input mux samples
	reg [`ACR_SW-1:0] gated [0:4]; // downmix inputs after enables
	reg [25:0] sum_l; // left downmix sum
	reg [25:0] sum_r; // right downmix sum
	reg [`ACR_SW-1:0] dm_left; // downmix left result
	reg [`ACR_SW-1:0] dm_right; // downmix right result
	reg [24:0] sum_lr; // left plus right
	reg [`ACR_SW-1:0] dm_avg; // half of left plus right
	reg [`ACR_CH_W-1:0] chan_data; // internal channels 1..6
	wire [`ACR_CH_W-1:0] pin_data; // pins after mapping

	// am decode intermediates
	reg [10:0] freq_nxt; // decoded kHz value
	reg valid_nxt; // field well formed
	integer i; // sample slot index

	// sign extend a sample to the sum width
	function [25:0] sx;
		input [`ACR_SW-1:0] d;
		begin
			sx = {{2{d[23]}}, d};
		end
	endfunction

	// half a sample, sign extended
	function [25:0] half;
		input [`ACR_SW-1:0] d;
		begin
			half = {{3{d[23]}}, d[23:1]};
		end
	endfunction

	// clip a sum back to a sample
	function [`ACR_SW-1:0] sat;
		input [25:0] s;
		begin
			if (s[25:23] == 3'h0 || s[25:23] == 3'h7)
				sat = s[23:0];
			else if (s[25])
				sat = 24'h800000;
			else
				sat = 24'h7fffff;
		end
	endfunction

	// a bcd digit is at most nine
	function digit_ok;
		input [3:0] d;
		begin
			digit_ok = (d <= 4'h9);
		end
	endfunction

	// frame buffer in front of the routing stage
	acr_fifo #(
		.W(`ACR_FRAME_W),
		.DEPTH(`ACR_FIFO_DEPTH),
		.AW(`ACR_FIFO_AW)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data({in_bass_data, in_mux_data}),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_data),
		.level(fifo_level)
	);

	// stage frees when the output is empty or being drained
	assign fifo_ready = ~out_valid | out_ready;
	assign take = fifo_valid & fifo_ready;

	// split the frame and run the downmix
	always @*
	begin
		for (i = 0; i < `ACR_NCH; i = i + 1)
			in_s[i] = fifo_data[i*`ACR_SW +: `ACR_SW];
		for (i = 0; i < 5; i = i + 1)
			gated[i] = act_dm_r[`ACR_DM_EN_LO + i] ? in_s[i] : {`ACR_SW{1'b0}};
		// inputs 1 and 2 are the fronts, 3 the centre, 4 and 5 the surrounds
		sum_l = sx(gated[0]) + half(gated[2]) + half(gated[3]);
		sum_r = sx(gated[1]) + half(gated[2]) + half(gated[4]);
		dm_left = sat(sum_l);
		dm_right = sat(sum_r);
		sum_lr = {dm_left[23], dm_left} + {dm_right[23], dm_right};
		dm_avg = sum_lr[24:1];
	end

	// internal channel sources; bits 31..16 and 7..5 are never looked at
	always @*
	begin
		chan_data = {`ACR_CH_W{1'b0}};
		if (act_dm_r[`ACR_DM_SEL_L])
			chan_data[0 +: `ACR_SW] = dm_left;
		else
			chan_data[0 +: `ACR_SW] = in_s[0];
		if (act_dm_r[`ACR_DM_SEL_R])
			chan_data[24 +: `ACR_SW] = dm_right;
		else
			chan_data[24 +: `ACR_SW] = in_s[1];
		chan_data[48 +: `ACR_SW] = in_s[2];
		chan_data[72 +: `ACR_SW] = in_s[3];
		if (act_dm_r[`ACR_DM_SEL_C5])
			chan_data[96 +: `ACR_SW] = dm_avg;
		else
			chan_data[96 +: `ACR_SW] = in_s[4];
		case (act_dm_r[`ACR_DM_CH6_LO +: 2])
			`ACR_CH6_DIRECT: chan_data[120 +: `ACR_SW] = in_s[5];
			`ACR_CH6_BASS: chan_data[120 +: `ACR_SW] = fifo_data[144 +: `ACR_SW];
			default: chan_data[120 +: `ACR_SW] = dm_avg;
		endcase
	end

	// channel to pin mapping
	acr_pin_mux u_pin_mux (
		.chan_data(chan_data),
		.pin_sel(act_out_r[23:0]),
		.pin_data(pin_data)
	);

	// tuned frequency decode in either format
	always @*
	begin
		freq_nxt = 11'h000;
		valid_nxt = 1'b0;
		if (am_r[`ACR_AM_FMT])
		begin
			freq_nxt = am_r[10:0];
			valid_nxt = (am_r[15:11] == 5'h00);
		end
		else
		begin
			freq_nxt = {10'h000, am_r[12]} * 11'd1000
				+ {7'h00, am_r[11:8]} * 11'd100
				+ {7'h00, am_r[7:4]} * 11'd10
				+ {7'h00, am_r[3:0]};
			valid_nxt = (am_r[15:13] == 3'h0) & digit_ok(am_r[11:8])
				& digit_ok(am_r[7:4]) & digit_ok(am_r[3:0]);
		end
		if (am_r[`ACR_AM_SEQ_LO +: 2] == `ACR_AM_SEQ_BAD)
			valid_nxt = 1'b0;
	end

	// software writes; reserved pattern bits 15..13 are kept as written
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			dm_r <= `ACR_DM_RST;
			am_r <= `ACR_AM_RST;
			outpin_r <= `ACR_OUT_RST;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`ACR_ADDR_DOWNMIX: dm_r <= reg_wdata & `ACR_DM_MASK;
				`ACR_ADDR_AM: am_r <= reg_wdata & `ACR_AM_MASK;
				`ACR_ADDR_OUTPIN: outpin_r <= reg_wdata & `ACR_OUT_MASK;
				default: ;
			endcase
		end
	end

	// register reads, one cycle later with a valid pulse
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			reg_rdata <= 32'h00000000;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
			begin
				case (reg_addr)
					`ACR_ADDR_DOWNMIX: reg_rdata <= dm_r;
					`ACR_ADDR_AM: reg_rdata <= am_r;
					`ACR_ADDR_OUTPIN: reg_rdata <= outpin_r;
					`ACR_ADDR_STATUS: reg_rdata <= {23'h000000, fifo_level,
						1'b0, am_freq_valid, 1'b0,
						(act_dm_r != dm_r) | (act_out_r != outpin_r)};
					default: reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// active routing reloads when a frame is taken or the fifo is empty, not while a frame waits
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			act_dm_r <= `ACR_DM_RST;
			act_out_r <= `ACR_OUT_RST;
		end
		else if (take | ~fifo_valid)
		begin
			act_dm_r <= dm_r;
			act_out_r <= outpin_r;
		end
	end

	// output frame register, whole frame moves at once
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			out_valid <= 1'b0;
			out_pin_data <= {`ACR_CH_W{1'b0}};
		end
		else
		begin
			if (take)
			begin
				out_valid <= 1'b1;
				out_pin_data <= pin_data;
			end
			else if (out_ready)
				out_valid <= 1'b0;
		end
	end

	// am controls to the modulator
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			am_enable <= 1'b0;
			am_sequence <= 2'h0;
			am_if_low <= 1'b0;
			am_freq_binary <= 1'b0;
			am_freq_khz <= 11'h000;
			am_freq_valid <= 1'b0;
		end
		else
		begin
			am_enable <= am_r[`ACR_AM_EN];
			am_sequence <= am_r[`ACR_AM_SEQ_LO +: 2];
			am_if_low <= am_r[`ACR_AM_IF];
			am_freq_binary <= am_r[`ACR_AM_FMT];
			am_freq_khz <= freq_nxt;
			am_freq_valid <= valid_nxt;
		end
	end
endmodule

`default_nettype wire

// ### acr_defs.vh
// constants for the audio channel routing block: offsets, fields, resets
// assumes inclusion by bare name from every design file of the block but the fifo
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH

// sample and frame geometry
`define ACR_SW 24
`define ACR_NCH 6
`define ACR_CH_W 144
`define ACR_FRAME_W 168
`define ACR_FIFO_DEPTH 16
`define ACR_FIFO_AW 4

// register offsets
`define ACR_ADDR_DOWNMIX 8'h21
`define ACR_ADDR_AM 8'h22
`define ACR_ADDR_OUTPIN 8'h25
`define ACR_ADDR_STATUS 8'h26

// downmix route select fields
`define ACR_DM_SEL_L 12
`define ACR_DM_SEL_R 11
`define ACR_DM_SEL_C5 10
`define ACR_DM_CH6_LO 8
`define ACR_DM_EN_LO 0
`define ACR_DM_RSV_LO 13

// channel-6 source codes
`define ACR_CH6_DIRECT 2'h0
`define ACR_CH6_BASS 2'h1

// am avoidance fields
`define ACR_AM_EN 20
`define ACR_AM_SEQ_LO 18
`define ACR_AM_IF 17
`define ACR_AM_FMT 16
`define ACR_AM_SEQ_BAD 2'h3

// writable bit masks, other bits read zero
`define ACR_DM_MASK 32'h0000ff1f
`define ACR_AM_MASK 32'h001fffff
`define ACR_OUT_MASK 32'h00ffffff

// reset values
`define ACR_DM_RST 32'h00004000
`define ACR_AM_RST 32'h00000000
`define ACR_OUT_RST 32'h00012345

// output pin code of the highest channel
`define ACR_CODE_MAX 4'h5

`endif

// ### acr_fifo.v
// acr_fifo: synchronous frame fifo with valid and ready on both sides
// assumes one clock, synchronous active-high reset, depth a power of two
`default_nettype none

module acr_fifo #(
	parameter integer W = 168,
	parameter integer DEPTH = 16,
	parameter integer AW = 4
) (
	input wire sys_clk,
	input wire rst,
	input wire in_valid,
	output reg in_ready,
	input wire [W-1:0] in_data,
	output reg out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data,
	output reg [AW:0] level
);
	localparam [AW:0] FULL_CNT = DEPTH[AW:0]; // full level
	localparam [AW:0] ONE = {{AW{1'b0}}, 1'b1}; // unit step

	reg [W-1:0] mem_r [0:DEPTH-1]; // frame storage
	reg [AW-1:0] wr_ptr_r; // next write slot
	reg [AW-1:0] rd_ptr_r; // oldest frame
	wire push; // frame accepted
	wire pop; // frame drained
	reg [AW:0] level_nxt; // next fill level

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_r[rd_ptr_r];

	// next fill level
	always @*
	begin
		level_nxt = level;
		if (push & ~pop)
			level_nxt = level + ONE;
		else if (pop & ~push)
			level_nxt = level - ONE;
	end

	// storage write, no reset needed for data
	always @(posedge sys_clk)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

	// pointers and registered full and empty flags
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			level <= {(AW+1){1'b0}};
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + ONE[AW-1:0];
			if (pop)
				rd_ptr_r <= rd_ptr_r + ONE[AW-1:0];
			level <= level_nxt;
			in_ready <= (level_nxt != FULL_CNT);
			out_valid <= (level_nxt != {(AW+1){1'b0}});
		end
	end
endmodule

`default_nettype wire

// ### acr_pin_mux.v
// acr_pin_mux: maps six internal channels onto six output pins
// assumes packed buses, channel 1 and pin 1 in the lowest sample slot
`default_nettype none
`include "acr_defs.vh"

module acr_pin_mux (
	input wire [`ACR_CH_W-1:0] chan_data,
	input wire [23:0] pin_sel,
	output wire [`ACR_CH_W-1:0] pin_data
);
	// one channel picked by its zero-based code, silence for unused codes
	function [`ACR_SW-1:0] pick;
		input [`ACR_CH_W-1:0] d;
		input [3:0] code;
		begin
			case (code)
				4'h0: pick = d[0 +: `ACR_SW];
				4'h1: pick = d[24 +: `ACR_SW];
				4'h2: pick = d[48 +: `ACR_SW];
				4'h3: pick = d[72 +: `ACR_SW];
				4'h4: pick = d[96 +: `ACR_SW];
				4'h5: pick = d[120 +: `ACR_SW];
				default: pick = {`ACR_SW{1'b0}};
			endcase
		end
	endfunction

	// pin 1 field sits at the top nibble, pin 6 at the bottom
	genvar p;
	generate
		for (p = 0; p < `ACR_NCH; p = p + 1)
		begin : g_pin
			assign pin_data[p*`ACR_SW +: `ACR_SW] =
				pick(chan_data, pin_sel[20-4*p +: 4]);
		end
	endgenerate
endmodule

`default_nettype wire

// ### acr_checker.sv
// acr_checker: port timing checks for the routing block
// assumes a bind onto acr_top from the testbench file
`default_nettype none
module acr_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [143:0] out_pin_data,
	input wire logic am_enable,
	input wire logic [1:0] am_sequence,
	input wire logic am_if_low,
	input wire logic am_freq_binary,
	input wire logic [10:0] am_freq_khz,
	input wire logic am_freq_valid
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// one am write, then a quiet cycle so outputs can settle
	sequence s_am_wr;
		reg_wr && reg_addr == 8'h22;
	endsequence
	sequence s_am_settle;
		s_am_wr ##1 !(reg_wr && reg_addr == 8'h22);
	endsequence
	a_am_follow:
	assert property (s_am_settle |=> {am_enable, am_sequence, am_if_low, am_freq_binary}
		== $past(reg_wdata[20:16], 2)) else $error("am controls wrong");
	a_bin_value:
	assert property (s_am_settle |=> am_freq_binary && am_freq_valid
		|-> am_freq_khz == $past(reg_wdata[10:0], 2)) else $error("binary freq wrong");
	a_bcd_bound:
	assert property (!am_freq_binary && am_freq_valid |-> am_freq_khz <= 11'h7cf)
		else $error("bcd freq too high");
	a_seq_bad:
	assert property (am_sequence == 2'h3 |-> !am_freq_valid) else $error("bad sequence valid");
	a_rd_answer:
	assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
	a_dm_unused:
	assert property (reg_rd && reg_addr == 8'h21 |=> reg_rdata[31:16] == 16'h0
		&& reg_rdata[7:5] == 3'h0) else $error("unused bits read back");
	a_pin_hold:
	assert property (out_valid && !out_ready |=> out_valid && $stable(out_pin_data))
		else $error("frame changed while held");
	a_frame_lat:
	assert property (in_valid && in_ready && !out_valid |-> ##[1:4] out_valid)
		else $error("frame not delivered");
endmodule
`default_nettype wire

// ### testbench.sv
// testbench: random and corner routing, register and am checks
// assumes acr_top and acr_checker are compiled before this file
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// stimulus, driven at the falling edge
	logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, in_valid = 1'b0;
	logic out_ready = 1'b0, reg_rvalid, in_ready, out_valid, am_enable, am_if_low;
	logic am_freq_binary, am_freq_valid;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, dm = 32'h00004000, om, v, reg_rdata;
	logic [143:0] in_mux_data = 144'h0, out_pin_data;
	logic [23:0] in_bass_data = 24'h0;
	logic [1:0] am_sequence;
	logic [10:0] am_freq_khz;
	logic [11:0] e;
	logic [143:0] exp_q[$]; // expected pin frames in take order
	logic [167:0] raw_q[$]; // offered {bass, mux} frames, same order as exp_q
	int bad_count = 0, checks = 0, i, n, sent;
	always #50 sys_clk = ~sys_clk;
	acr_top i_dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.reg_rvalid, .in_valid, .in_ready, .in_mux_data, .in_bass_data, .out_valid,
		.out_ready, .out_pin_data, .am_enable, .am_sequence, .am_if_low, .am_freq_binary,
		.am_freq_khz, .am_freq_valid);
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	function automatic logic [23:0] sat(input logic signed [25:0] s);
		if (s > 26'sh7fffff) return 24'h7fffff;
		if (s < -26'sh800000) return 24'h800000;
		return s[23:0];
	endfunction
	// expected pins for one frame under dm and om
	function automatic logic [143:0] route(input logic [143:0] f, input logic [23:0] b);
		logic signed [25:0] s[5];
		logic signed [24:0] t;
		logic [23:0] c[6], l, r;
		logic [143:0] o;
		for (int j = 0; j < 6; j++) c[j] = f[24*j+:24];
		for (int j = 0; j < 5; j++) s[j] = dm[j] ? $signed(f[24*j+:24]) : 26'sh0;
		l = sat(s[0] + (s[2] >>> 1) + (s[3] >>> 1));
		r = sat(s[1] + (s[2] >>> 1) + (s[4] >>> 1));
		t = ($signed({l[23], l}) + $signed({r[23], r})) >>> 1;
		if (dm[12]) c[0] = l;
		if (dm[11]) c[1] = r;
		if (dm[10]) c[4] = t[23:0];
		if (dm[9:8] == 2'h1) c[5] = b;
		if (dm[9]) c[5] = t[23:0];
		for (int p = 0; p < 6; p++) o[24*p+:24] = (om[23-4*p-:4] < 4'h6) ? c[om[23-4*p-:4]] : 24'h0;
		return o;
	endfunction
	// expected {valid, khz} of an am register word
	function automatic logic [11:0] am_exp(input logic [31:0] w);
		logic [15:0] k;
		logic ok;
		k = w[16] ? {5'h0, w[10:0]} : {15'h0, w[12]} * 16'h03e8 + {12'h0, w[11:8]} * 16'h0064
			+ {12'h0, w[7:4]} * 16'h000a + {12'h0, w[3:0]};
		ok = w[16] ? w[15:11] == 5'h0 : w[15:13] == 3'h0 && w[11:8] < 4'ha && w[7:4] < 4'ha
			&& w[3:0] < 4'ha;
		return {ok && w[19:18] != 2'h3, k[10:0]};
	endfunction
	function automatic logic [143:0] rnd();
		logic [159:0] t;
		t = {$urandom, $urandom, $urandom, $urandom, $urandom};
		return t[143:0];
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		chk(reg_rvalid === 1'b1 && reg_rdata === x, "register read");
	endtask
	// offer one frame once there is room; gives up after 40 cycles
	task automatic send(input logic [143:0] f, input logic [23:0] b);
		n = 0;
		@(negedge sys_clk);
		while (in_ready !== 1'b1 && n < 40)
		begin
			in_valid = 1'b0;
			n++;
			@(negedge sys_clk);
		end
		in_valid = (n < 40);
		in_mux_data = f;
		in_bass_data = b;
		if (n < 40)
		begin
			exp_q.push_back(route(f, b));
			raw_q.push_back({b, f});
		end
		sent += (n < 40);
	endtask
	task automatic drain();
		@(negedge sys_clk);
		in_valid = 1'b0;
		out_ready = 1'b1;
		n = 0;
		while (exp_q.size() > 0 && n < 100)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk(exp_q.size() == 0, "frames lost");
	endtask
	// compare each handed-over frame in order
	always @(posedge sys_clk)
	begin
		if (!rst && out_valid === 1'b1 && out_ready === 1'b1)
		begin
			if (exp_q.size() == 0) chk(1'b0, "extra frame");
			else
			begin
				chk(out_pin_data === exp_q.pop_front(), "pins");
				void'(raw_q.pop_front());
			end
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// watchdog well past the expected run length
	initial
	begin
		#2000000;
		bad_count++;
		$display("mismatch %0t watchdog", $time);
		end_sim();
	end
	initial
	begin
		v = $urandom(21);
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		rd(8'h21, 32'h00004000);
		rd(8'h22, 32'h00000000);
		rd(8'h25, 32'h00012345);
		rd(8'h30, 32'h00000000);
		rd(8'h26, 32'h00000004); // status: am field valid, fifo empty, routing in step
		wr(8'h21, 32'hffffffff);
		rd(8'h21, 32'h0000ff1f);
		$display("test registers done");
		for (i = 0; i < 40; i++)
		begin
			dm = ($urandom & 32'hffff1fff) | 32'h00004000;
			if (i < 4) dm[9:8] = i[1:0];
			om = $urandom;
			for (n = 0; n < 6; n++) om[4*n+:4] = (i % 8 == 7) ? 4'($urandom) : 4'($urandom_range(5, 0));
			if (i == 4) om = 32'h0;
			if (i == 5) om = 32'h00555555;
			wr(8'h21, dm);
			wr(8'h25, om);
			repeat (2) @(negedge sys_clk);
			out_ready = 1'($urandom);
			send(i % 5 == 0 ? {6{24'h7fffff}} : i % 5 == 1 ? {6{24'h800000}} : rnd(), 24'($urandom));
			send(rnd(), 24'($urandom));
			send(rnd(), 24'($urandom));
			drain();
		end
		$display("test routing done");
		// fill until refused, then remap while frames wait
		out_ready = 1'b0;
		sent = 0;
		repeat (20) send(rnd(), 24'($urandom));
		chk(sent >= 16 && sent <= 17, "fifo depth");
		om = om ^ 32'h00111111;
		wr(8'h25, om);
		// held frame and fifo head keep the old map, later frames take the new one
		for (n = 2; n < exp_q.size(); n++)
		begin
			exp_q[n] = route(raw_q[n][143:0], raw_q[n][167:144]);
		end
		drain();
		$display("test fill done");
		for (i = 0; i < 32; i++)
		begin
			v = $urandom & 32'h001fffff;
			v[19:16] = i[3:0];
			if (i < 16) v[15:0] = v[16] ? {5'h0, v[10:0]} : {3'h0, v[12],
				4'($urandom_range(9, 0)), 4'($urandom_range(9, 0)), 4'($urandom_range(9, 0))};
			if (i == 2) v[15:0] = 16'h1999;
			if (i == 3) v[15:0] = 16'h07ff;
			wr(8'h22, v);
			@(negedge sys_clk);
			e = am_exp(v);
			chk({am_enable, am_sequence, am_if_low, am_freq_binary} === v[20:16], "am");
			chk(am_freq_valid === e[11] && (!e[11] || am_freq_khz === e[10:0]), "freq");
		end
		$display("test am done");
		end_sim();
	end
endmodule
bind acr_top acr_checker i_chk (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .reg_rvalid, .in_valid, .in_ready, .out_valid, .out_ready, .out_pin_data,
	.am_enable, .am_sequence, .am_if_low, .am_freq_binary, .am_freq_khz, .am_freq_valid);
`default_nettype wire
